// [srac_service_request_ack_chain.v]
// Purpose: service request outputs, acknowledge chain and vector readback
// Assumes: host bus pins are asynchronous to sys_clk; request sources
//          (rx/tx/modem pending) come from logic on sys_clk
// Notes:   open-drain pins are split into out and enable signals
// Operation
// - Three request pins are open-drain, only ever pulled low.
// - Upper five vector bits hold programmable identity, returned in each ack.
// - Ack in plus data strobe with chip select idle is a hardware ack cycle.
// - Reading an ack register acknowledges the request and returns the vector.
// - Vector bits two to zero carry the type of request acknowledged.
// - Ack register read, none pending, chaining on: assert ack out.
// - Ack register read, none pending, chaining off: low bits read zero.
// - Hardware ack cycles acknowledge as register reads do; with none pending they assert ack out even with chaining off.
// - Status register: three own request bits, three wired-OR line bits.
// - Hardware ack with own request pending drives vector onto data bus.
`timescale 1ns/1ps
`include "srac_regs.vh"

module srac_service_request_ack_chain (
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire       chipSel_n,
    input  wire       data_strobe_n,
    input  wire       readNotWrite,
    input  wire [6:0] addr,
    input  wire [7:0] wrData,
    input  wire       ack_chain_in_n,
    input  wire       chainEnable,
    input  wire       rxPending,
    input  wire       txPending,
    input  wire       modemPending,
    input  wire       rxReqLineIn,
    input  wire       txReqLineIn,
    input  wire       modemReqLineIn,
    output reg        rxReqLineOut,
    output reg        rxReqLineOe,
    output reg        txReqLineOut,
    output reg        txReqLineOe,
    output reg        modemReqLineOut,
    output reg        modemReqLineOe,
    output reg        ack_chain_out_n,
    output reg  [7:0] rdData,
    output reg        rdDataOe,
    output reg        rxAck,
    output reg        txAck,
    output reg        modemAck,
    output reg  [4:0] deviceId
);

    localparam PIN_W = 23;
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_DRIVE = 2'd1;
    localparam [1:0] ST_PASS  = 2'd2;
    localparam [1:0] ST_HOLD  = 2'd3;

    // Reset release
    reg  [1:0]       rstSync;
    wire             rstN = rstSync[1];

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    // Pin synchronisers, a change counts once stages two and three agree
    wire [PIN_W-1:0] pinRaw = {modemReqLineIn, txReqLineIn, rxReqLineIn,
                               ack_chain_in_n, wrData, addr, readNotWrite,
                               data_strobe_n, chipSel_n};
    reg  [PIN_W-1:0] sync1;
    reg  [PIN_W-1:0] sync2;
    reg  [PIN_W-1:0] sync3;
    reg  [PIN_W-1:0] pinQ;

    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            sync1 <= {PIN_W{1'b1}};
            sync2 <= {PIN_W{1'b1}};
            sync3 <= {PIN_W{1'b1}};
        end else begin
            sync1 <= pinRaw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1) begin : gFilt
            always @(posedge sys_clk or negedge rstN) begin
                if (!rstN) begin
                    pinQ[gi] <= 1'b1;
                end else if (sync2[gi] == sync3[gi]) begin
                    pinQ[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    wire       csAct    = ~pinQ[0];
    wire       dsAct    = ~pinQ[1];
    wire       isRead   = pinQ[2];
    wire [6:0] addrQ    = pinQ[9:3];
    wire [7:0] wrDataQ  = pinQ[17:10];
    wire       ackInAct = ~pinQ[18];
    wire [2:0] extReq   = ~pinQ[21:19];

    wire hwAckCyc = ackInAct & dsAct & ~csAct;
    wire cpuCyc   = csAct & dsAct & ~ackInAct;
    reg  [1:0] state;
    reg  [7:0] globalVector;
    wire       startHw  = (state == ST_IDLE) & hwAckCyc;
    wire       startCpu = (state == ST_IDLE) & cpuCyc;

    // Ack register index to type code, none for other addresses
    function [2:0] ackCodeOf;
        input [6:0] a;
        begin
            case (a)
                `SRAC_IDX_RX_ACK:    ackCodeOf = `SRAC_CODE_RX;
                `SRAC_IDX_TX_ACK:    ackCodeOf = `SRAC_CODE_TX;
                `SRAC_IDX_MODEM_ACK: ackCodeOf = `SRAC_CODE_MODEM;
                default:             ackCodeOf = `SRAC_CODE_NONE;
            endcase
        end
    endfunction

    wire [2:0] swCode = ackCodeOf(addrQ);
    wire       swPend = (swCode == `SRAC_CODE_RX    & rxPending) |
                        (swCode == `SRAC_CODE_TX    & txPending) |
                        (swCode == `SRAC_CODE_MODEM & modemPending);
    // Hardware ack takes highest pending type: rx, then tx, then modem
    wire [2:0] hwCode = rxPending ? `SRAC_CODE_RX :
                        txPending ? `SRAC_CODE_TX :
                        modemPending ? `SRAC_CODE_MODEM : `SRAC_CODE_NONE;
    wire       anyPend = rxPending | txPending | modemPending;
    wire [2:0] code    = startHw ? hwCode : swCode;
    // Identity in upper bits, type code in low bits
    wire [7:0] vector  = {globalVector[`SRAC_GVR_ID_MSB:`SRAC_GVR_ID_LSB],
                          code};
    wire [7:0] statusWord = {2'b00, extReq, modemPending, txPending,
                             rxPending};

    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            state           <= ST_IDLE;
            globalVector    <= `SRAC_GVR_RESET;
            rdData          <= 8'h00;
            rdDataOe        <= 1'b0;
            ack_chain_out_n <= 1'b1;
            rxAck           <= 1'b0;
            txAck           <= 1'b0;
            modemAck        <= 1'b0;
        end else begin
            rxAck    <= 1'b0;
            txAck    <= 1'b0;
            modemAck <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (startHw) begin
                        if (anyPend) begin
                            // Drive vector, ack same as read
                            rdData   <= vector;
                            rdDataOe <= 1'b1;
                            rxAck    <= (hwCode == `SRAC_CODE_RX);
                            txAck    <= (hwCode == `SRAC_CODE_TX);
                            modemAck <= (hwCode == `SRAC_CODE_MODEM);
                            state    <= ST_DRIVE;
                        end else begin
                            ack_chain_out_n <= 1'b0;
                            state           <= ST_PASS;
                        end
                    end else if (startCpu && !isRead) begin
                        if (addrQ == `SRAC_IDX_GLOBAL_VECTOR) begin
                            globalVector <= wrDataQ;
                        end
                        state <= ST_HOLD;
                    end else if (startCpu && swCode != `SRAC_CODE_NONE) begin
                        if (swPend) begin
                            rdData   <= vector;
                            rdDataOe <= 1'b1;
                            rxAck    <= (swCode == `SRAC_CODE_RX);
                            txAck    <= (swCode == `SRAC_CODE_TX);
                            modemAck <= (swCode == `SRAC_CODE_MODEM);
                            state    <= ST_DRIVE;
                        end else if (chainEnable) begin
                            // Nothing here, hand on down the chain
                            ack_chain_out_n <= 1'b0;
                            state           <= ST_PASS;
                        end else begin
                            rdData   <= {vector[7:3], `SRAC_CODE_NONE};
                            rdDataOe <= 1'b1;
                            state    <= ST_DRIVE;
                        end
                    end else if (startCpu) begin
                        rdData   <= (addrQ == `SRAC_IDX_REQUEST_STATUS) ?
                                    statusWord :
                                    (addrQ == `SRAC_IDX_GLOBAL_VECTOR) ?
                                    globalVector : 8'h00;
                        rdDataOe <= 1'b1;
                        state    <= ST_DRIVE;
                    end
                end
                ST_DRIVE, ST_PASS, ST_HOLD: begin
                    // Cycle ends when the strobe drops
                    if (!dsAct) begin
                        rdDataOe        <= 1'b0;
                        ack_chain_out_n <= 1'b1;
                        state           <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Open-drain request pins, only ever pull low
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rxReqLineOut    <= 1'b0;
            txReqLineOut    <= 1'b0;
            modemReqLineOut <= 1'b0;
            rxReqLineOe     <= 1'b0;
            txReqLineOe     <= 1'b0;
            modemReqLineOe  <= 1'b0;
            deviceId        <= 5'h00;
        end else begin
            rxReqLineOut    <= 1'b0;
            txReqLineOut    <= 1'b0;
            modemReqLineOut <= 1'b0;
            rxReqLineOe     <= rxPending;
            txReqLineOe     <= txPending;
            modemReqLineOe  <= modemPending;
            deviceId <= globalVector[`SRAC_GVR_ID_MSB:`SRAC_GVR_ID_LSB];
        end
    end

endmodule // srac_service_request_ack_chain

// [srac_regs.vh]
// Purpose: constants for the service request acknowledge chain block
// Assumes: included by srac_service_request_ack_chain.v only
// Notes:   register indices are seven-bit chip addresses
`ifndef SRAC_REGS_VH
`define SRAC_REGS_VH

// Register indices on the address pins
`define SRAC_IDX_GLOBAL_VECTOR  7'h40
`define SRAC_IDX_REQUEST_STATUS 7'h41
`define SRAC_IDX_RX_ACK         7'h42
`define SRAC_IDX_TX_ACK         7'h43
`define SRAC_IDX_MODEM_ACK      7'h44

// Reset values
`define SRAC_GVR_RESET          8'h00

// Field positions
`define SRAC_GVR_ID_MSB         7
`define SRAC_GVR_ID_LSB         3
`define SRAC_ID_WIDTH           5
`define SRAC_STAT_OWN_LSB       0
`define SRAC_STAT_EXT_LSB       3

// Request type codes placed in vector bits 2..0
`define SRAC_CODE_NONE          3'h0
`define SRAC_CODE_MODEM         3'h1
`define SRAC_CODE_TX            3'h2
`define SRAC_CODE_RX            3'h3

// Synchroniser depth for pin inputs
`define SRAC_SYNC_STAGES        3
`endif

// [srac_properties.sv]
// Purpose: port assertions for the ack chain block
// Assumes: bus cycles hold the strobe low well past the answer
// Notes:   bound to the top module
`timescale 1ns/1ps
module srac_properties (
    input wire       sys_clk,
    input wire       rst_b,
    input wire       data_strobe_n,
    input wire       rxPending,
    input wire       rxReqLineOut,
    input wire       rxReqLineOe,
    input wire       ack_chain_out_n,
    input wire [7:0] rdData,
    input wire       rdDataOe,
    input wire       rxAck,
    input wire       txAck,
    input wire       modemAck,
    input wire [4:0] deviceId
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    wire anyAck = rxAck | txAck | modemAck;
    property p_pin;
        !rxReqLineOut && (rxReqLineOe == $past(rxPending));
    endproperty
    a_pin: assert property (p_pin) else $error("pin not pull-down");
    property p_pulse; anyAck |=> !anyAck; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_code; anyAck |-> rdDataOe &&
        rdData[2:0] == (rxAck ? 3'h3 : (txAck ? 3'h2 : 3'h1)); endproperty
    a_code: assert property (p_code) else $error("bad type code");
    property p_id; anyAck |-> rdData[7:3] == deviceId; endproperty
    a_id: assert property (p_id) else $error("bad identity");
    property p_strobe; anyAck |-> !data_strobe_n; endproperty
    a_strobe: assert property (p_strobe) else $error("ack w/o strobe");
    property p_pass; !ack_chain_out_n |-> !rdDataOe && !anyAck; endproperty
    a_pass: assert property (p_pass) else $error("pass while driving");
    property p_fell; $fell(ack_chain_out_n) |-> !data_strobe_n; endproperty
    a_fell: assert property (p_fell) else $error("pass w/o strobe");
    property p_rel;
        data_strobe_n[*8] |-> ack_chain_out_n && !rdDataOe;
    endproperty
    a_rel: assert property (p_rel) else $error("not released");
    property p_hold; $rose(rdDataOe) |=> rdDataOe[*3]; endproperty
    a_hold: assert property (p_hold) else $error("vector dropped");
    c_rx: cover property (rxAck);
    c_modem: cover property (modemAck);
    c_pass: cover property ($fell(ack_chain_out_n));
endmodule // srac_properties

bind srac_service_request_ack_chain srac_properties u_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .data_strobe_n(data_strobe_n),
    .rxPending(rxPending), .rxReqLineOut(rxReqLineOut),
    .rxReqLineOe(rxReqLineOe), .ack_chain_out_n(ack_chain_out_n),
    .rdData(rdData), .rdDataOe(rdDataOe), .rxAck(rxAck), .txAck(txAck),
    .modemAck(modemAck), .deviceId(deviceId));

// [srac_line_partner.sv]
// Purpose: wired-OR request lines shared with other devices
// Assumes: pull-ups, so a released line reads high
// Notes:   otherPull stands in for other devices' requests
`timescale 1ns/1ps
module srac_line_partner (
    input  wire [2:0] ownOe,
    input  wire [2:0] otherPull,
    output wire [2:0] lineLvl
);
    assign lineLvl = ~(ownOe | otherPull);
endmodule // srac_line_partner

// [test_service_request_ack_chain.sv]
// Purpose: bench for the ack chain block
// Assumes: strobe held 10 clocks, answer within 6
// Notes:   bit order of 3-bit buses is modem, tx, rx
`timescale 1ns/1ps
module test_service_request_ack_chain;
    reg        sys_clk = 1'b0;
    reg        rst_b = 1'b0;
    reg        csN = 1'b1;
    reg        dsN = 1'b1;
    reg        rnw = 1'b1;
    reg  [6:0] addr = 7'h00;
    reg  [7:0] wrData = 8'h00;
    reg        ackInN = 1'b1;
    reg        chainEnable = 1'b1;
    reg  [2:0] pend = 3'h0;
    reg  [2:0] otherPull = 3'h0;
    reg  [2:0] acks;
    reg        sOe;
    reg        sOut;
    reg  [7:0] sData;
    wire [2:0] lineOut, lineOe, lineLvl, ackP;
    wire       ackOutN, rdDataOe;
    wire [7:0] rdData;
    wire [4:0] deviceId;
    integer    fails = 0;
    integer    n_tests = 0;
    srac_line_partner part (.ownOe(lineOe), .otherPull(otherPull),
        .lineLvl(lineLvl));
    srac_service_request_ack_chain uut (.sys_clk(sys_clk), .rst_b(rst_b),
        .chipSel_n(csN), .data_strobe_n(dsN), .readNotWrite(rnw),
        .addr(addr), .wrData(wrData), .ack_chain_in_n(ackInN),
        .chainEnable(chainEnable), .rxPending(pend[0]),
        .txPending(pend[1]), .modemPending(pend[2]),
        .rxReqLineIn(lineLvl[0]), .txReqLineIn(lineLvl[1]),
        .modemReqLineIn(lineLvl[2]), .rxReqLineOut(lineOut[0]),
        .rxReqLineOe(lineOe[0]), .txReqLineOut(lineOut[1]),
        .txReqLineOe(lineOe[1]), .modemReqLineOut(lineOut[2]),
        .modemReqLineOe(lineOe[2]), .ack_chain_out_n(ackOutN),
        .rdData(rdData), .rdDataOe(rdDataOe), .rxAck(ackP[0]),
        .txAck(ackP[1]), .modemAck(ackP[2]), .deviceId(deviceId));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task chk(input string what, input [7:0] seen, input [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            $display("BAD %s exp %h seen %h", what, exp, seen);
            fails = fails + 1;
        end
    endtask
    // One bus cycle; entered and left 10 ns after an edge
    // Select and ack exclusive, bar refusal check
    task bus(input cs, input ai, input rw, input [6:0] a, input [7:0] d);
        csN = cs;
        ackInN = ai;
        rnw = rw;
        addr = a;
        wrData = d;
        dsN = 1'b0;
        acks = 3'h0;
        repeat (10) begin
            @(posedge sys_clk);
            #1 acks = acks | ackP;
        end
        {sOe, sOut, sData} = {rdDataOe, ackOutN, rdData};
        // Ack in drops with strobe, long gap
        #9 {dsN, csN, ackInN} = 3'h7;
        repeat (12) @(posedge sys_clk);
        #10;
    endtask
    task t_id;
        bus(1'b0, 1'b1, 1'b0, 7'h40, 8'hA8);
        chk("deviceId", {3'h0, deviceId}, 8'h15);
        bus(1'b0, 1'b1, 1'b1, 7'h40, 8'h00);
        chk("vector", sData, 8'hA8);
        $display("identity test done");
    endtask
    task t_acks;
        pend = 3'h3;
        bus(1'b1, 1'b0, 1'b1, 7'h00, 8'h00);
        chk("hwOe", {7'h00, sOe}, 8'h01);
        chk("hwVec", sData, 8'hAB);
        chk("hwAck", {5'h00, acks}, 8'h01);
        chk("reqOe", {5'h00, lineOe}, 8'h03);
        pend = 3'h2;
        bus(1'b0, 1'b1, 1'b1, 7'h43, 8'h00);
        chk("txVec", sData, 8'hAA);
        chk("txAck", {5'h00, acks}, 8'h02);
        pend = 3'h4;
        bus(1'b0, 1'b1, 1'b1, 7'h44, 8'h00);
        chk("mdVec", sData, 8'hA9);
        chk("mdAck", {5'h00, acks}, 8'h04);
        chk("mdOe", {5'h00, lineOe}, 8'h04);
        pend = 3'h0;
        $display("acknowledge test done");
    endtask
    task t_fish;
        bus(1'b0, 1'b1, 1'b1, 7'h42, 8'h00);
        chk("passOut", {3'h0, sOe, sOut, acks}, 8'h00);
        chainEnable = 1'b0;
        bus(1'b0, 1'b1, 1'b1, 7'h42, 8'h00);
        chk("fishVec", sData, 8'hA8);
        chk("fishOe", {3'h0, sOe, sOut, acks}, 8'h18);
        chainEnable = 1'b1;
        bus(1'b1, 1'b0, 1'b1, 7'h00, 8'h00);
        chk("hwPass", {3'h0, sOe, sOut, acks}, 8'h00);
        $display("empty acknowledge test done");
    endtask
    task t_status;
        pend = 3'h1;
        otherPull = 3'h2;
        repeat (3) @(posedge sys_clk);
        #10;
        chk("reqPins", {2'h0, lineOut, lineOe}, 8'h01);
        // Status read, then ack what is pending
        bus(1'b0, 1'b1, 1'b1, 7'h41, 8'h00);
        chk("status", sData, 8'h19);
        bus(1'b0, 1'b1, 1'b1, 7'h42, 8'h00);
        chk("rxVec", sData, 8'hAB);
        chk("rxAck", {5'h00, acks}, 8'h01);
        bus(1'b0, 1'b0, 1'b1, 7'h42, 8'h00);
        chk("clash", {3'h0, sOe, sOut, acks}, 8'h08);
        {pend, otherPull} = 6'h00;
        $display("status test done");
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails = fails + 1;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #10 rst_b = 1'b1;
        repeat (10) @(posedge sys_clk);
        #10;
        t_id;
        t_acks;
        t_fish;
        t_status;
        complete_run;
    end
endmodule // test_service_request_ack_chain
